// *** core/nvac_controller.v ***
// cpu-side byte access controller for the 512-byte nonvolatile data array
`timescale 1ns/10ps
`include "nvac_regs.vh"
module nvac_controller #(
  parameter WRITE_OSC_CYCLES = `NVAC_WRITE_OSC_CYCLES,  // oscillator cycles per write
  parameter OSC_DIVIDE       = `NVAC_CLOCK_MHZ / `NVAC_OSC_MHZ  // system cycles per osc tick
) (
  input  wire       clock,             // system clock, 100 MHz
  input  wire       reset_n,           // async reset, active low
  input  wire [7:0] busAddress,        // register byte address
  input  wire [7:0] busWriteData,      // write data
  input  wire       busWrite,          // write strobe
  input  wire       busRead,           // read strobe
  output reg  [7:0] busReadData,       // read data, cycle after read strobe
  input  wire       globalIrqEnable,   // global interrupt flag of cpu status word
  input  wire       selfProgramActive, // flash self-programming busy, asynchronous
  output reg        cpuStall,          // halts cpu instruction flow
  output reg        readyIrq,          // ready interrupt request
  output reg        irq,               // masked event interrupt
  output reg  [8:0] arrayAddress,      // array byte address
  output reg  [7:0] arrayWriteData,    // array write byte
  output reg        arrayWriteEnable,  // array programming active
  output reg        arrayReadEnable,   // array read pulse
  input  wire [7:0] arrayReadData      // array read byte, combinational
);

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  localparam IDLE    = 1'b0;
  localparam WRITING = 1'b1;

  reg        state;
  reg [8:0]  nvAddress;
  reg [7:0]  nvDataByte;
  reg        readyIrqEnable;
  reg        writeArm;
  reg [2:0]  armCount;
  reg [2:0]  stallCount;
  reg [13:0] oscCount;
  reg [`NVAC_IRQ_BITS-1:0] irqStatus;
  reg [`NVAC_IRQ_BITS-1:0] irqMask;

  wire       oscTick;
  wire       flashBusy;
  wire       writeStrobe = (state == WRITING);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  function [2:0] countDown;
    input [2:0] value;
    begin
      countDown = (value == 3'h0) ? 3'h0 : value - 3'h1;
    end
  endfunction

  nvac_sync flashSync (
    .clock   (clock),
    .reset_n (reset_n),
    .din     (selfProgramActive),
    .dout    (flashBusy)
  );

  nvac_osc_tick #(
    .DIVIDE (OSC_DIVIDE)
  ) oscTicker (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (oscTick)
  );

  // ----------------------------------------
  // decoded write requests
  // ----------------------------------------
  wire ctrlWrite  = busWrite && hit(busAddress, `NVAC_OFF_CONTROL);
  wire armReq     = ctrlWrite && busWriteData[`NVAC_BIT_WRITE_ARM]
                    && !busWriteData[`NVAC_BIT_WRITE_STROBE];
  wire strobeReq  = ctrlWrite && busWriteData[`NVAC_BIT_WRITE_STROBE] && !writeStrobe;
  wire startWrite = strobeReq && writeArm && !flashBusy;
  wire dropWrite  = strobeReq && !startWrite;
  wire readReq    = ctrlWrite && busWriteData[`NVAC_BIT_READ_STROBE] && !writeStrobe;
  wire oscDone    = writeStrobe && oscTick && (oscCount == 14'h0001);
  wire [`NVAC_IRQ_BITS-1:0] irqEvents = {dropWrite, readReq, oscDone};

  // ----------------------------------------
  // address and data registers, never reset
  // ----------------------------------------
  always @(posedge clock) begin
    if (busWrite && !writeStrobe && hit(busAddress, `NVAC_OFF_ADDR_LOW))
      nvAddress[7:0] <= busWriteData;
    if (busWrite && !writeStrobe && hit(busAddress, `NVAC_OFF_ADDR_HIGH))
      nvAddress[8] <= busWriteData[0];
    if (readReq)
      nvDataByte <= arrayReadData;
    else if (busWrite && !writeStrobe && hit(busAddress, `NVAC_OFF_DATA))
      nvDataByte <= busWriteData;
  end

  always @* begin
    arrayAddress = nvAddress;
  end

  // ----------------------------------------
  // write sequencing, survives reset
  // ----------------------------------------
  always @(posedge clock) begin
    case (state)
      IDLE: begin
        if (startWrite) begin
          state          <= WRITING;
          oscCount       <= WRITE_OSC_CYCLES[13:0];
          arrayWriteData <= nvDataByte;
        end
      end
      WRITING: begin
        if (oscTick)
          oscCount <= oscCount - 14'h0001;
        if (oscDone)
          state <= IDLE;
      end
      default: state <= IDLE;
    endcase
  end

  // power-up state of the sequencer without a reset term
  initial state = IDLE;
  initial oscCount = 14'h0000;
  initial arrayWriteData = 8'h00;

  always @* begin
    arrayWriteEnable = writeStrobe;
  end

  // ----------------------------------------
  // control bits, stall and interrupts
  // ----------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readyIrqEnable <= 1'b0;
      writeArm       <= 1'b0;
      armCount       <= 3'h0;
      stallCount     <= 3'h0;
      cpuStall       <= 1'b0;
      readyIrq       <= 1'b0;
      irq            <= 1'b0;
      arrayReadEnable <= 1'b0;
      irqStatus      <= {`NVAC_IRQ_BITS{1'b0}};
      irqMask        <= {`NVAC_IRQ_BITS{1'b0}};
    end else begin
      if (ctrlWrite)
        readyIrqEnable <= busWriteData[`NVAC_BIT_READY_IRQ_EN];
      if (armReq) begin
        writeArm <= 1'b1;
        armCount <= `NVAC_ARM_CYCLES;
      end else if (startWrite || armCount == 3'h1) begin
        writeArm <= 1'b0;
        armCount <= 3'h0;
      end else begin
        armCount <= countDown(armCount);
      end

      if (startWrite)
        stallCount <= `NVAC_WRITE_STALL;
      else if (readReq)
        stallCount <= `NVAC_READ_STALL;
      else
        stallCount <= countDown(stallCount);
      cpuStall <= startWrite || readReq || (stallCount > 3'h1);

      readyIrq <= readyIrqEnable && globalIrqEnable && !writeStrobe && !startWrite;
      // registered pulse, never beside a write that starts on the same strobe
      arrayReadEnable <= readReq && !startWrite;

      if (busWrite && hit(busAddress, `NVAC_OFF_IRQ_MASK))
        irqMask <= busWriteData[`NVAC_IRQ_BITS-1:0];
      if (busWrite && hit(busAddress, `NVAC_OFF_IRQ_STATUS))
        irqStatus <= (irqStatus & ~busWriteData[`NVAC_IRQ_BITS-1:0]) | irqEvents;
      else
        irqStatus <= irqStatus | irqEvents;
      irq <= |(irqStatus & irqMask);
    end
  end

  // ----------------------------------------
  // register read back
  // ----------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busReadData <= 8'h00;
    end else if (busRead) begin
      case (busAddress)
        `NVAC_OFF_ADDR_LOW:   busReadData <= nvAddress[7:0];
        `NVAC_OFF_ADDR_HIGH:  busReadData <= {7'h00, nvAddress[8]};
        `NVAC_OFF_DATA:       busReadData <= nvDataByte;
        `NVAC_OFF_CONTROL:    busReadData <= {4'h0, readyIrqEnable, writeArm,
                                              writeStrobe, 1'b0};
        `NVAC_OFF_IRQ_STATUS: busReadData <= {5'h00, irqStatus};
        `NVAC_OFF_IRQ_MASK:   busReadData <= {5'h00, irqMask};
        default:              busReadData <= 8'h00;
      endcase
    end else begin
      busReadData <= 8'h00;
    end
  end
endmodule

// *** core/nvac_regs.vh ***
// register map, field positions and timing constants of the nonvolatile access controller
`ifndef NVAC_REGS_VH
`define NVAC_REGS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define NVAC_ADDR_WIDTH      8
`define NVAC_OFF_ADDR_LOW    8'h00
`define NVAC_OFF_ADDR_HIGH   8'h04
`define NVAC_OFF_DATA        8'h08
`define NVAC_OFF_CONTROL     8'h0c
`define NVAC_OFF_IRQ_STATUS  8'h10
`define NVAC_OFF_IRQ_MASK    8'h14

// ----------------------------------------
// control register fields
// ----------------------------------------
`define NVAC_BIT_READ_STROBE   0
`define NVAC_BIT_WRITE_STROBE  1
`define NVAC_BIT_WRITE_ARM     2
`define NVAC_BIT_READY_IRQ_EN  3

// ----------------------------------------
// interrupt status fields
// ----------------------------------------
`define NVAC_IRQ_WRITE_DONE    0
`define NVAC_IRQ_READ_DONE     1
`define NVAC_IRQ_WRITE_DROPPED 2
`define NVAC_IRQ_BITS          3

// ----------------------------------------
// timing
// ----------------------------------------
`define NVAC_ARM_CYCLES        3'h4
`define NVAC_WRITE_STALL       3'h2
`define NVAC_READ_STALL        3'h4
`define NVAC_WRITE_OSC_CYCLES  8448
`define NVAC_CLOCK_MHZ         100
`define NVAC_OSC_MHZ           1

`endif

// *** core/nvac_sync.v ***
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module nvac_sync (
  input  wire clock,    // system clock
  input  wire reset_n,  // async reset, active low
  input  wire din,      // asynchronous level
  output reg  dout      // synchronised level
);
  reg stage;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage <= 1'b0;
      dout  <= 1'b0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule

// *** core/nvac_osc_tick.v ***
// one-cycle tick per calibrated oscillator period, derived from the system clock
`timescale 1ns/10ps
`include "nvac_regs.vh"
module nvac_osc_tick #(
  parameter DIVIDE = `NVAC_CLOCK_MHZ / `NVAC_OSC_MHZ  // system cycles per oscillator cycle
) (
  input  wire clock,    // system clock
  input  wire reset_n,  // async reset, active low
  output reg  tick      // one pulse per oscillator cycle
);
  reg [7:0] count;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (count == DIVIDE[7:0] - 8'h01) begin
      count <= 8'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule

// *** test/nvac_controller_props.sv ***
// concurrent checks on the controller ports
`timescale 1ns/10ps
`include "nvac_regs.vh"
module nvac_controller_props #(
  parameter WRITE_OSC_CYCLES = `NVAC_WRITE_OSC_CYCLES, // oscillator cycles per write
  parameter OSC_DIVIDE       = 100                     // system cycles per tick
) (
  input wire       clock,            // system clock
  input wire       reset_n,          // async reset, active low
  input wire [7:0] busAddress,       // register address
  input wire [7:0] busWriteData,     // write data
  input wire       busWrite,         // write strobe
  input wire       busRead,          // read strobe
  input wire [7:0] busReadData,      // read data
  input wire       globalIrqEnable,  // global interrupt flag
  input wire       cpuStall,         // cpu halt
  input wire       readyIrq,         // ready interrupt
  input wire [8:0] arrayAddress,     // array address
  input wire [7:0] arrayWriteData,   // array write byte
  input wire       arrayWriteEnable, // programming active
  input wire       arrayReadEnable   // array read pulse
);
  localparam int WLO = (WRITE_OSC_CYCLES - 1) * OSC_DIVIDE + 1;
  localparam int WHI = WRITE_OSC_CYCLES * OSC_DIVIDE;
  wire ctrlWr = busWrite && busAddress == `NVAC_OFF_CONTROL;
  // length of the current write in system cycles; a reset inside it stalls the tick
  reg [31:0] wlen = 32'h0;
  reg        wcut = 1'b0;
  always @(posedge clock) begin
    if (!arrayWriteEnable) begin
      wlen <= 32'h0;
      wcut <= 1'b0;
    end else begin
      wlen <= wlen + 32'h1;
      if (!reset_n)
        wcut <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_ctrl_rsvd_zero: assert property (busRead && busAddress == `NVAC_OFF_CONTROL |=> busReadData[7:4] == 4'h0)
    else $error("control reserved bits not zero");
  a_addr_rsvd_zero: assert property (busRead && busAddress == `NVAC_OFF_ADDR_HIGH |=> busReadData[7:1] == 7'h00)
    else $error("address high reserved bits not zero");
  a_ready_off_busy: assert property (arrayWriteEnable && $past(arrayWriteEnable) |-> !readyIrq)
    else $error("ready interrupt during write");
  a_ready_needs_gie: assert property (!$past(globalIrqEnable) |-> !readyIrq)
    else $error("ready interrupt without global enable");
  a_write_stall: assert property ($rose(arrayWriteEnable) |-> cpuStall ##1 cpuStall ##1 !cpuStall)
    else $error("write stall not two cycles");
  a_read_stall: assert property (ctrlWr && busWriteData[0] && !arrayWriteEnable |=> cpuStall[*4] ##1 !cpuStall)
    else $error("read stall not four cycles");
  a_no_read_busy: assert property (arrayReadEnable |-> !arrayWriteEnable)
    else $error("array read during write");
  a_addr_frozen: assert property (arrayWriteEnable && $past(arrayWriteEnable) |-> $stable(arrayAddress))
    else $error("address moved during write");
  a_wdata_frozen: assert property (arrayWriteEnable && $past(arrayWriteEnable) |-> $stable(arrayWriteData))
    else $error("write byte moved during write");
  a_strobe_cause: assert property ($rose(arrayWriteEnable) |-> $past(ctrlWr) && $past(busWriteData[1]))
    else $error("write started without strobe");
  a_write_len: assert property ($fell(arrayWriteEnable) && !wcut |-> wlen >= WLO && wlen <= WHI)
    else $error("write duration wrong");
endmodule
bind nvac_controller nvac_controller_props #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES), .OSC_DIVIDE(OSC_DIVIDE)) u_props (
  .clock(clock), .reset_n(reset_n), .busAddress(busAddress), .busWriteData(busWriteData), .busWrite(busWrite),
  .busRead(busRead), .busReadData(busReadData), .globalIrqEnable(globalIrqEnable), .cpuStall(cpuStall),
  .readyIrq(readyIrq), .arrayAddress(arrayAddress), .arrayWriteData(arrayWriteData),
  .arrayWriteEnable(arrayWriteEnable), .arrayReadEnable(arrayReadEnable));

// *** test/nvac_array_model.sv ***
// byte array standing behind the controller
`timescale 1ns/10ps
module nvac_array_model (
  input  wire       clock,            // system clock
  input  wire [8:0] arrayAddress,     // byte address
  input  wire [7:0] arrayWriteData,   // byte to program
  input  wire       arrayWriteEnable, // programming active
  output wire [7:0] arrayReadData     // byte at address
);
  reg [7:0] mem [0:511];
  integer   k;
  initial begin
    for (k = 0; k < 512; k = k + 1)
      mem[k] = 8'hff;
  end
  always @(posedge clock) begin
    if (arrayWriteEnable)
      mem[arrayAddress] <= arrayWriteData;
  end
  // wrong data while programming
  assign arrayReadData = arrayWriteEnable ? ~mem[arrayAddress] : mem[arrayAddress];
endmodule

// *** test/nvac_controller_tb.sv ***
// self-checking bench for the nonvolatile access controller
`timescale 1ns/10ps
`include "nvac_regs.vh"
module nvac_controller_tb;
  reg        clock = 1'b0;
  reg        reset_n = 1'b0;
  reg  [7:0] busAddress = 8'h00;
  reg  [7:0] busWriteData = 8'h00;
  reg        busWrite = 1'b0;
  reg        busRead = 1'b0;
  reg        globalIrqEnable = 1'b0;
  reg        selfProgramActive = 1'b0;
  wire [7:0] busReadData, arrayWriteData, arrayReadData;
  wire [8:0] arrayAddress;
  wire       cpuStall, readyIrq, irq, arrayWriteEnable, arrayReadEnable;
  integer    errTotal = 0;
  integer    testsRun = 0;
  integer    cycles = 0;
  integer    i;
  reg  [7:0] rdata;
  always #5 clock = ~clock;
  nvac_controller #(.WRITE_OSC_CYCLES(4), .OSC_DIVIDE(2)) u_nvac_controller (
    .clock(clock), .reset_n(reset_n), .busAddress(busAddress), .busWriteData(busWriteData), .busWrite(busWrite),
    .busRead(busRead), .busReadData(busReadData), .globalIrqEnable(globalIrqEnable),
    .selfProgramActive(selfProgramActive), .cpuStall(cpuStall), .readyIrq(readyIrq), .irq(irq),
    .arrayAddress(arrayAddress), .arrayWriteData(arrayWriteData), .arrayWriteEnable(arrayWriteEnable),
    .arrayReadEnable(arrayReadEnable), .arrayReadData(arrayReadData));
  nvac_array_model u_nvac_array_model (.clock(clock), .arrayAddress(arrayAddress), .arrayWriteData(arrayWriteData),
    .arrayWriteEnable(arrayWriteEnable), .arrayReadData(arrayReadData));
  task chk(input [8:0] seen, input [8:0] exp);
    begin
      testsRun = testsRun + 1;
      if (seen !== exp) begin
        errTotal = errTotal + 1;
        $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      busAddress <= a;
      busWriteData <= d;
      busWrite <= 1'b1;
      @(posedge clock);
      busWrite <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clock);
      busAddress <= a;
      busRead <= 1'b1;
      @(posedge clock);
      busRead <= 1'b0;
      #1 rdata = busReadData;
    end
  endtask
  task wait_idle;
    begin
      rd(`NVAC_OFF_CONTROL);
      for (i = 0; i < 40 && rdata[1] !== 1'b0; i = i + 1)
        rd(`NVAC_OFF_CONTROL);
      chk(rdata[1], 1'b0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d, mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errTotal = errTotal + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rd(`NVAC_OFF_CONTROL); chk(rdata, 8'h00);
    wr(`NVAC_OFF_CONTROL, 8'hf0); rd(`NVAC_OFF_CONTROL); chk(rdata, 8'h00);
    rd(8'h20); chk(rdata, 8'h00);
    wr(`NVAC_OFF_ADDR_LOW, 8'hff); wr(`NVAC_OFF_ADDR_HIGH, 8'hff);
    rd(`NVAC_OFF_ADDR_HIGH); chk(rdata, 8'h01);
    wr(`NVAC_OFF_DATA, 8'ha5); wr(`NVAC_OFF_IRQ_MASK, 8'h01);
    wr(`NVAC_OFF_CONTROL, 8'h04); wr(`NVAC_OFF_CONTROL, 8'h02);
    rd(`NVAC_OFF_CONTROL); chk({rdata[7:4], rdata[1]}, 5'h01);
    wr(`NVAC_OFF_ADDR_LOW, 8'h00); rd(`NVAC_OFF_ADDR_LOW); chk(rdata, 8'hff);
    wait_idle;
    chk(u_nvac_array_model.mem[9'h1ff], 8'ha5);
    chk(irq, 1'b1);
    wr(`NVAC_OFF_IRQ_STATUS, 8'h07); rd(`NVAC_OFF_IRQ_STATUS); chk(rdata, 8'h00); chk(irq, 1'b0);
    wr(`NVAC_OFF_DATA, 8'h00); wr(`NVAC_OFF_CONTROL, 8'h01);
    rd(`NVAC_OFF_DATA); chk(rdata, 8'ha5);
    wr(`NVAC_OFF_CONTROL, 8'h04); rd(`NVAC_OFF_CONTROL); chk(rdata, 8'h04);
    repeat (2) @(posedge clock);
    wr(`NVAC_OFF_CONTROL, 8'h02); rd(`NVAC_OFF_CONTROL); chk(rdata, 8'h00);
    rd(`NVAC_OFF_IRQ_STATUS); chk(rdata, 8'h06); chk(irq, 1'b0);
    wr(`NVAC_OFF_IRQ_STATUS, 8'h06);
    @(posedge clock); selfProgramActive <= 1'b1;
    wr(`NVAC_OFF_CONTROL, 8'h04); wr(`NVAC_OFF_CONTROL, 8'h02);
    rd(`NVAC_OFF_CONTROL); chk(rdata, 8'h04);
    @(posedge clock); selfProgramActive <= 1'b0; globalIrqEnable <= 1'b1;
    wr(`NVAC_OFF_CONTROL, 8'h08); rd(`NVAC_OFF_CONTROL); chk(readyIrq, 1'b1);
    wr(`NVAC_OFF_CONTROL, 8'h0c); wr(`NVAC_OFF_CONTROL, 8'h0a);
    rd(`NVAC_OFF_CONTROL); chk(readyIrq, 1'b0);
    wait_idle;
    repeat (2) @(posedge clock);
    #1 chk(readyIrq, 1'b1);
    @(posedge clock);
    globalIrqEnable <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk(readyIrq, 1'b0);
    wr(`NVAC_OFF_ADDR_LOW, 8'h10); wr(`NVAC_OFF_ADDR_HIGH, 8'h00); wr(`NVAC_OFF_DATA, 8'h3c);
    wr(`NVAC_OFF_CONTROL, 8'h04); wr(`NVAC_OFF_CONTROL, 8'h02);
    @(posedge clock); reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (30) @(posedge clock);
    chk(u_nvac_array_model.mem[9'h010], 8'h3c);
    rd(`NVAC_OFF_CONTROL); chk(rdata, 8'h00);
    tally_and_finish;
  end
endmodule
